// *** shared/carr_pkg.sv ***
// Purpose: Shared constants and types of the counter array.
// Assumes: Registers sit on the special function register port of the core.
// Notes:   Register addresses are local to the block's address space.
package carr_pkg;
    // ************************************************************
    // Sizes and register addresses
    // ************************************************************
    localparam int         NUM_MOD          = 5;
    localparam logic [7:0] ADDR_CTRL_FLAGS  = 8'h00;
    localparam logic [7:0] ADDR_ARRAY_MODE  = 8'h01;
    localparam logic [7:0] ADDR_CNT_LO      = 8'h02;
    localparam logic [7:0] ADDR_CNT_HI      = 8'h03;
    localparam logic [7:0] ADDR_MODE_BASE   = 8'h04;
    localparam logic [7:0] ADDR_VAL_LO_BASE = 8'h09;
    localparam logic [7:0] ADDR_VAL_HI_BASE = 8'h0E;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_OVF_BIT     = 7;
    localparam int CTRL_RUN_BIT     = 6;
    localparam int AMODE_IDLE_BIT   = 7;
    localparam int AMODE_WDT_BIT    = 6;
    localparam int AMODE_SRC_HI_BIT = 2;
    localparam int AMODE_SRC_LO_BIT = 1;
    localparam int AMODE_OVFIE_BIT  = 0;
    localparam int PIN_EXT_CNT_BIT  = 2;
    localparam int PIN_MOD0_BIT     = 3;
    // ************************************************************
    // Reset values and cycle counts
    // ************************************************************
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
    localparam logic [7:0]  PIN_IDLE   = 8'hFF;
    localparam logic [3:0]  DIV_SLOW   = 4'hC;
    localparam logic [1:0]  DIV_FAST_LAST = 2'h3;

    // Count source selection.
    typedef enum logic [1:0] {
        SRC_OSC12 = 2'b00,
        SRC_OSC4  = 2'b01,
        SRC_T0    = 2'b10,
        SRC_EXT   = 2'b11
    } carr_src_type;

    // Layout of one module mode register.
    typedef struct packed {
        logic rsv;
        logic comparator_en;
        logic capture_rise_en;
        logic capture_fall_en;
        logic match_flag_en;
        logic match_toggle_en;
        logic pwm_en;
        logic module_irq_en;
    } carr_mode_type;
endpackage

// *** hw/carr_top.sv ***
// Purpose: Counter array with five capture/compare modules and a shared time base.
// Assumes: Core drives the register port on the same clock; pins are asynchronous.
// Notes:   Read data appears one clock after the address is presented.
// ************************************************************
// ************************************************************
`timescale 1ns/100ps
module carr_top (
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic [7:0] SFR_ADDR_I,
    input  wire logic       SFR_WR_I,
    input  wire logic [7:0] SFR_WDATA_I,
    output logic      [7:0] SFR_RDATA_O,
    input  wire logic       IDLE_I,
    input  wire logic       T0_OVF_I,
    input  wire logic [7:0] P1_IN_I,
    output logic      [7:0] P1_OUT_O,
    output logic      [7:0] P1_OE_O,
    output logic            IRQ_O,
    output logic            WATCHDOG_RST_O
);
    import carr_pkg::*;

    logic [7:0]         sync1_reg;
    logic [7:0]         sync2_reg;
    logic [7:0]         pin_prev_reg;
    logic [3:0]         presc_reg;
    logic [3:0]         presc_next;
    logic [15:0]        cnt_reg;
    logic [15:0]        cnt_inc;
    logic [7:0]         amode_reg;
    logic               cf_reg;
    logic               run_reg;
    logic [NUM_MOD-1:0] ccf_reg;
    logic [NUM_MOD-1:0] ccf_next;
    logic               cf_next;
    logic               irq_reg;
    logic               wdt_reg;
    logic [7:0]         rd_reg;
    logic [7:0]         rd_next;
    logic               tick_slow;
    logic               tick_fast;
    logic               ext_fall;
    logic               tick_sel;
    logic               run;
    logic               inc;
    logic               ovf;
    logic               wr_ctrl;
    logic               wr_amode;
    logic               wr_cnt_lo;
    logic               wr_cnt_hi;
    logic               cnt_wr;
    carr_src_type       src_sel;
    logic [NUM_MOD-1:0] match_evt;
    logic [NUM_MOD-1:0] cap_evt;
    logic [NUM_MOD-1:0] flag_set;
    logic [NUM_MOD-1:0] irq_en_vec;
    logic [NUM_MOD-1:0] mod_out;
    logic [NUM_MOD-1:0] mod_oe;
    logic [7:0]         mode_rd [NUM_MOD];
    logic [15:0]        val_rd  [NUM_MOD];

    // Every assertion samples the core clock and rests while reset is low.
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    // ************************************************************
    // Pin synchronisers and edge detectors
    // ************************************************************
    // Two stages per pin, then a third stage that only the edge logic compares.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            sync1_reg    <= PIN_IDLE;
            sync2_reg    <= PIN_IDLE;
            pin_prev_reg <= PIN_IDLE;
        end else begin
            sync1_reg    <= P1_IN_I;
            sync2_reg    <= sync1_reg;
            pin_prev_reg <= sync2_reg;
        end
    end

    // ************************************************************
    // Count source and time base
    // ************************************************************
    // Register strobes and count source decode.
    assign wr_ctrl   = SFR_WR_I && (SFR_ADDR_I == ADDR_CTRL_FLAGS);
    assign wr_amode  = SFR_WR_I && (SFR_ADDR_I == ADDR_ARRAY_MODE);
    assign wr_cnt_lo = SFR_WR_I && (SFR_ADDR_I == ADDR_CNT_LO);
    assign wr_cnt_hi = SFR_WR_I && (SFR_ADDR_I == ADDR_CNT_HI);
    assign cnt_wr    = wr_cnt_lo || wr_cnt_hi;
    assign src_sel   = carr_src_type'({amode_reg[AMODE_SRC_HI_BIT], amode_reg[AMODE_SRC_LO_BIT]});
    assign presc_next = (presc_reg == DIV_SLOW - 4'h1) ? 4'h0 : presc_reg + 4'h1;
    assign tick_slow = (presc_reg == DIV_SLOW - 4'h1);
    assign tick_fast = (presc_reg[1:0] == DIV_FAST_LAST);
    assign ext_fall  = pin_prev_reg[PIN_EXT_CNT_BIT] && !sync2_reg[PIN_EXT_CNT_BIT];
    assign tick_sel  = (src_sel == SRC_OSC12) ? tick_slow :
                       (src_sel == SRC_OSC4)  ? tick_fast :
                       (src_sel == SRC_T0)    ? T0_OVF_I  : ext_fall;
    assign run       = run_reg && !(IDLE_I && amode_reg[AMODE_IDLE_BIT]);
    assign inc       = run && tick_sel;
    assign cnt_inc   = cnt_reg + 16'h0001;
    assign ovf       = inc && (cnt_reg == CNT_ALL_ONES);

    // Oscillator prescaler, free running.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            presc_reg <= 4'h0;
        end else begin
            presc_reg <= presc_next;
        end
    end

    // Shared counter; a software write takes priority over a count.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            cnt_reg <= RST_WORD;
        end else if (wr_cnt_lo) begin
            cnt_reg[7:0] <= SFR_WDATA_I;
        end else if (wr_cnt_hi) begin
            cnt_reg[15:8] <= SFR_WDATA_I;
        end else if (inc) begin
            cnt_reg <= cnt_inc;
        end
    end

    // ************************************************************
    // Capture/compare modules
    // ************************************************************
    for (genvar i = 0; i < NUM_MOD; i++) begin : g_mod
        carr_mode_type mode_reg;
        logic [15:0]   val_reg;
        logic [7:0]    duty_reg;
        logic          out_reg;
        logic          rise;
        logic          fall;
        logic          wr_mode;
        logic          wr_lo;
        logic          wr_hi;
        logic          wrap_lo;

        // Decode, edges and events of this module.
        assign wr_mode = SFR_WR_I && (SFR_ADDR_I == ADDR_MODE_BASE + 8'(i));
        assign wr_lo   = SFR_WR_I && (SFR_ADDR_I == ADDR_VAL_LO_BASE + 8'(i));
        assign wr_hi   = SFR_WR_I && (SFR_ADDR_I == ADDR_VAL_HI_BASE + 8'(i));
        assign rise    = !pin_prev_reg[PIN_MOD0_BIT+i] && sync2_reg[PIN_MOD0_BIT+i];
        assign fall    = pin_prev_reg[PIN_MOD0_BIT+i] && !sync2_reg[PIN_MOD0_BIT+i];
        assign cap_evt[i]   = (mode_reg.capture_rise_en && rise) ||
                              (mode_reg.capture_fall_en && fall);
        assign match_evt[i] = inc && mode_reg.comparator_en && (cnt_inc == val_reg);
        assign flag_set[i]  = cap_evt[i] ||
                              (match_evt[i] && mode_reg.match_flag_en);
        assign wrap_lo      = inc && (cnt_reg[7:0] == CNT_ALL_ONES[7:0]);
        assign irq_en_vec[i] = mode_reg.module_irq_en;
        assign mod_out[i]   = out_reg;
        assign mod_oe[i]    = mode_reg.pwm_en || mode_reg.match_toggle_en;
        assign mode_rd[i]   = mode_reg;
        assign val_rd[i]    = val_reg;

        // Mode register and value pair; a capture wins over a software write.
        always_ff @(posedge REF_CLK_I) begin
            if (!RST_N_I) begin
                mode_reg <= carr_mode_type'(RST_BYTE);
                val_reg  <= RST_WORD;
            end else begin
                if (wr_mode) begin
                    mode_reg <= carr_mode_type'(SFR_WDATA_I);
                end
                if (cap_evt[i]) begin
                    val_reg <= cnt_reg;
                end else if (wr_lo) begin
                    val_reg[7:0] <= SFR_WDATA_I;
                end else if (wr_hi) begin
                    val_reg[15:8] <= SFR_WDATA_I;
                end
            end
        end

        // Output pin: duty compare in modulation mode, else toggle on match.
        always_ff @(posedge REF_CLK_I) begin
            if (!RST_N_I) begin
                duty_reg <= RST_BYTE;
                out_reg  <= 1'b1;
            end else begin
                if (wrap_lo) begin
                    duty_reg <= val_reg[15:8];
                end
                if (mode_reg.pwm_en) begin
                    out_reg <= (cnt_reg[7:0] >= duty_reg);
                end else if (match_evt[i] && mode_reg.match_toggle_en) begin
                    out_reg <= !out_reg;
                end
            end
        end

        AST_CAPTURE_LOAD: assert property (cap_evt[i] |=> val_reg == $past(cnt_reg))
            else $error("Capture did not load the counter value.");
        // Each module checks its own flag, capture and output behaviour.
        AST_MATCH_FLAG: assert property (
            match_evt[i] && mode_reg.match_flag_en |=> ccf_reg[i])
            else $error("Match did not set the module flag.");
        AST_CAPTURE_FLAG: assert property (cap_evt[i] |=> ccf_reg[i])
            else $error("Capture did not set the module flag.");
        AST_PWM_HIGH: assert property (
            mode_reg.pwm_en && cnt_reg[7:0] >= duty_reg |=> out_reg)
            else $error("Modulated output low at or above the duty value.");
        AST_PWM_LOW: assert property (
            mode_reg.pwm_en && cnt_reg[7:0] < duty_reg |=> !out_reg)
            else $error("Modulated output high below the duty value.");
        AST_TOGGLE: assert property (match_evt[i] && mode_reg.match_toggle_en && !mode_reg.pwm_en
                                     |=> out_reg != $past(out_reg))
            else $error("Output did not toggle on match.");
    end

    // ************************************************************
    // Control flags, interrupt and watchdog
    // ************************************************************
    // Hardware sets win over a software clear in the same cycle.
    assign cf_next  = (wr_ctrl ? SFR_WDATA_I[CTRL_OVF_BIT] : cf_reg) || ovf;
    assign ccf_next = (wr_ctrl ? SFR_WDATA_I[NUM_MOD-1:0] : ccf_reg) | flag_set;

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            amode_reg <= RST_BYTE;
            cf_reg    <= 1'b0;
            run_reg   <= 1'b0;
            ccf_reg   <= '0;
            irq_reg   <= 1'b0;
            wdt_reg   <= 1'b0;
        end else begin
            if (wr_amode) begin
                amode_reg <= SFR_WDATA_I;
            end
            if (wr_ctrl) begin
                run_reg <= SFR_WDATA_I[CTRL_RUN_BIT];
            end
            cf_reg  <= cf_next;
            ccf_reg <= ccf_next;
            irq_reg <= (cf_reg && amode_reg[AMODE_OVFIE_BIT]) ||
                       |(ccf_reg & irq_en_vec);
            wdt_reg <= amode_reg[AMODE_WDT_BIT] && match_evt[NUM_MOD-1];
        end
    end

    // ************************************************************
    // Register read path
    // ************************************************************
    // Selects the addressed register; unused and reserved bits read zero.
    always_comb begin
        rd_next = RST_BYTE;
        case (SFR_ADDR_I)
            ADDR_CTRL_FLAGS: rd_next = {cf_reg, run_reg, 1'b0, ccf_reg};
            ADDR_ARRAY_MODE: rd_next = amode_reg & 8'hC7;
            ADDR_CNT_LO:     rd_next = cnt_reg[7:0];
            ADDR_CNT_HI:     rd_next = cnt_reg[15:8];
            default: begin
                for (int k = 0; k < NUM_MOD; k++) begin
                    if (SFR_ADDR_I == ADDR_MODE_BASE + 8'(k)) begin
                        rd_next = mode_rd[k] & 8'h7F;
                    end
                    if (SFR_ADDR_I == ADDR_VAL_LO_BASE + 8'(k)) begin
                        rd_next = val_rd[k][7:0];
                    end
                    if (SFR_ADDR_I == ADDR_VAL_HI_BASE + 8'(k)) begin
                        rd_next = val_rd[k][15:8];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            rd_reg <= RST_BYTE;
        end else begin
            rd_reg <= rd_next;
        end
    end

    // Output pins: module pins from bit 3 upward, count input pin never driven.
    assign SFR_RDATA_O    = rd_reg;
    assign IRQ_O          = irq_reg;
    assign WATCHDOG_RST_O = wdt_reg;
    assign P1_OUT_O       = {mod_out, 3'b000};
    assign P1_OE_O        = {mod_oe, 3'b000};

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_OVF_SETS_FLAG: assert property (ovf |=> cf_reg)
        else $error("Overflow did not set the flag.");
    AST_OVF_FLAG_HOLDS: assert property (cf_reg && !wr_ctrl |=> cf_reg)
        else $error("Overflow flag cleared without a write.");
    AST_MOD_FLAG_HOLDS: assert property (
        !wr_ctrl |=> (ccf_reg & $past(ccf_reg)) == $past(ccf_reg))
        else $error("Module flag cleared without a write.");
    AST_OVF_IRQ: assert property (cf_reg && amode_reg[AMODE_OVFIE_BIT] |=> IRQ_O)
        else $error("Enabled overflow flag gave no interrupt.");
    AST_NO_IRQ: assert property (!cf_reg && (ccf_reg == '0) |=> !IRQ_O)
        else $error("Interrupt without any flag.");
    AST_HALTED: assert property (!run_reg && !cnt_wr |=> $stable(cnt_reg))
        else $error("Counter moved while halted.");
    AST_IDLE_STOP: assert property (IDLE_I && amode_reg[AMODE_IDLE_BIT] && !cnt_wr
                                    |=> $stable(cnt_reg))
        else $error("Counter moved in idle with idle stop set.");
    AST_WRAP: assert property (ovf && !cnt_wr |=> cnt_reg == RST_WORD)
        else $error("Counter did not wrap to zero.");
    AST_SLOW_DIV: assert property (tick_slow |=> (!tick_slow)[*8])
        else $error("Slow prescaler ticked too early.");
    AST_WDT_OFF: assert property (!amode_reg[AMODE_WDT_BIT] |=> !WATCHDOG_RST_O)
        else $error("Watchdog reset while disabled.");
    AST_WDT_PULSE: assert property (
        amode_reg[AMODE_WDT_BIT] && match_evt[NUM_MOD-1] |=> WATCHDOG_RST_O)
        else $error("Enabled module 4 match gave no watchdog pulse.");

    COV_OVF: cover property (ovf ##1 IRQ_O);
    COV_CAPTURE: cover property (|cap_evt);
    COV_WDT: cover property (WATCHDOG_RST_O);
    COV_EXT_COUNT: cover property (src_sel == SRC_EXT && inc);
    COV_PWM_LOW: cover property (|(mod_oe & ~mod_out));
endmodule

// *** test/carr_pin_model.sv ***
// Purpose: Pin-side model of port 1 in front of the counter array.
// Assumes: Port 1 lines have pull-ups, so a released line reads high.
// Notes:   Every level is held for at least 3 clocks of the core clock.
`timescale 1ns/100ps
module carr_pin_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] oe_i,
    output logic      [7:0] pin_o
);
    logic [7:0] drv_reg = 8'hFF;

    // The wire shows the design's value where it drives, else the model's level.
    assign pin_o = (oe_i & out_i) | (~oe_i & drv_reg);

    // Sets one pin after an edge and holds it long enough for the synchroniser.
    task automatic set_pin(input int b, input logic v);
        @(posedge clk_i);
        drv_reg[b] <= v;
        repeat (3) @(posedge clk_i);
    endtask

    // Sends falling edges on the external count input line.
    task automatic ext_pulses(input int n);
        repeat (n) begin
            set_pin(2, 1'b0);
            set_pin(2, 1'b1);
        end
    endtask
endmodule

// *** test/programmable_counter_array_tb.sv ***
// Purpose: Self-checking bench for the counter array top.
// Assumes: Timer 0 pulses come from the bench, so counts are exact.
// Notes:   Register expectations come from a masked shadow copy.
`timescale 1ns/100ps
module programmable_counter_array_tb;
    import carr_pkg::*;
    // ************************************************************
    // Signals, design and pin model
    // ************************************************************
    logic       clk   = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr  = 8'h00;
    logic       wr_en = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic       idle  = 1'b0;
    logic       t0    = 1'b0;
    logic [7:0] rdata;
    logic [7:0] pin_in;
    logic [7:0] p_out;
    logic [7:0] p_oe;
    logic       irq;
    logic       wd_rst;
    logic       pv;
    logic [7:0] exp_reg [0:18];
    int         n_fail  = 0;
    int         n_tests = 0;
    int         seed    = 71;
    int         wd_cnt  = 0;

    // Free-running clock and a counter of watchdog pulses.
    always #2 clk = ~clk;
    always @(posedge clk) if (wd_rst === 1'b1) wd_cnt <= wd_cnt + 1;

    carr_top dut (
        .REF_CLK_I      (clk),
        .RST_N_I        (rst_n),
        .SFR_ADDR_I     (addr),
        .SFR_WR_I       (wr_en),
        .SFR_WDATA_I    (wdata),
        .SFR_RDATA_O    (rdata),
        .IDLE_I         (idle),
        .T0_OVF_I       (t0),
        .P1_IN_I        (pin_in),
        .P1_OUT_O       (p_out),
        .P1_OE_O        (p_oe),
        .IRQ_O          (irq),
        .WATCHDOG_RST_O (wd_rst)
    );
    carr_pin_model pins (.clk_i(clk), .out_i(p_out), .oe_i(p_oe), .pin_o(pin_in));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Compares one value and counts the result.
    task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
        n_tests++;
        if (seen !== expv) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    // Reserved bits read back as zero, so the shadow keeps only live bits.
    function automatic logic [7:0] wmask(input logic [7:0] a);
        if (a == ADDR_CTRL_FLAGS) return 8'hDF;
        if (a == ADDR_ARRAY_MODE) return 8'hC7;
        if (a >= ADDR_MODE_BASE && a < ADDR_VAL_LO_BASE) return 8'h7F;
        return 8'hFF;
    endfunction
    // One write: the strobe stands for exactly one edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wr_en <= 1'b1;
        wdata <= v;
        @(posedge clk);
        wr_en <= 1'b0;
        if (a < 8'h13) exp_reg[a] = v & wmask(a);
    endtask
    // One read: data follows the address one edge later.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 chk(16'(rdata), 16'(e));
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            t0 <= 1'b1;
            @(posedge clk);
            t0 <= 1'b0;
        end
    endtask
    task automatic set_cnt(input logic [15:0] v);
        wr(ADDR_CNT_LO, v[7:0]);
        wr(ADDR_CNT_HI, v[15:8]);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Prints the verdict and ends the run.
    task automatic final_report();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // Reset state of registers, an unmapped address and the pins.
        for (int a = 0; a < 20; a++) rd(8'(a), 8'h00);
        chk(16'({p_oe, p_out}), 16'h00F8);
        // Random values read back through the shadow, then everything cleared.
        for (int a = 1; a < 19; a++) begin
            wr(8'(a), 8'($random(seed)));
            rd(8'(a), exp_reg[a]);
        end
        for (int a = 1; a < 19; a++) wr(8'(a), 8'h00);
        wr(8'h13, 8'hA5);
        rd(8'h13, 8'h00);
        // Divided oscillator sources over a window of exactly ten periods.
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_ARRAY_MODE, s[0] ? 8'h02 : 8'h00);
            set_cnt(16'h0000);
            wr(ADDR_CTRL_FLAGS, 8'h40);
            repeat (s[0] ? 38 : 118) @(posedge clk);
            wr(ADDR_CTRL_FLAGS, 8'h00);
            repeat (24) @(posedge clk);
            rd(ADDR_CNT_LO, 8'h0A);
        end
        // External count input.
        wr(ADDR_ARRAY_MODE, 8'h06);
        set_cnt(16'h0000);
        wr(ADDR_CTRL_FLAGS, 8'h40);
        pins.ext_pulses(3);
        rd(ADDR_CNT_LO, 8'h03);
        // Timer 0 source, wrap, overflow flag and its interrupt enable.
        wr(ADDR_ARRAY_MODE, 8'h05);
        set_cnt(16'hFFFE);
        tick(2);
        rd(ADDR_CNT_HI, 8'h00);
        rd(ADDR_CTRL_FLAGS, 8'hC0);
        chk(16'(irq), 16'h0001);
        wr(ADDR_ARRAY_MODE, 8'h04);
        tick(1);
        chk(16'(irq), 16'h0000);
        rd(ADDR_CTRL_FLAGS, 8'hC0);
        wr(ADDR_CTRL_FLAGS, 8'h40);
        rd(ADDR_CTRL_FLAGS, 8'h40);
        // Idle stop halts counting only while its bit is set.
        wr(ADDR_ARRAY_MODE, 8'h84);
        set_cnt(16'h0000);
        @(posedge clk);
        idle <= 1'b1;
        tick(3);
        rd(ADDR_CNT_LO, 8'h00);
        wr(ADDR_ARRAY_MODE, 8'h04);
        tick(3);
        rd(ADDR_CNT_LO, 8'h03);
        @(posedge clk);
        idle <= 1'b0;
        // Module 0 compare with toggle, match flag and interrupt.
        set_cnt(16'h0000);
        wr(ADDR_VAL_LO_BASE, 8'h05);
        wr(ADDR_MODE_BASE, 8'h4D);
        #1 pv = p_out[3];
        tick(4);
        rd(ADDR_CTRL_FLAGS, 8'h40);
        tick(1);
        rd(ADDR_CTRL_FLAGS, 8'h41);
        chk(16'({p_oe[3], p_out[3]}), 16'({1'b1, ~pv}));
        chk(16'(irq), 16'h0001);
        tick(2);
        rd(ADDR_CTRL_FLAGS, 8'h41);
        wr(ADDR_MODE_BASE, 8'h00);
        wr(ADDR_CTRL_FLAGS, 8'h40);
        // Module 4 match gives a watchdog pulse only when enabled.
        wr(ADDR_ARRAY_MODE, 8'h44);
        set_cnt(16'h0000);
        wr(ADDR_VAL_LO_BASE + 8'h04, 8'h03);
        wr(ADDR_MODE_BASE + 8'h04, 8'h48);
        tick(3);
        rd(ADDR_CTRL_FLAGS, 8'h50);
        chk(16'(wd_cnt), 16'h0001);
        wr(ADDR_ARRAY_MODE, 8'h04);
        set_cnt(16'h0000);
        tick(3);
        settle(2);
        chk(16'(wd_cnt), 16'h0001);
        wr(ADDR_MODE_BASE + 8'h04, 8'h00);
        wr(ADDR_CTRL_FLAGS, 8'h00);
        // Module 1 capture on a rising edge, then on a falling edge.
        set_cnt(16'h1234);
        wr(ADDR_MODE_BASE + 8'h01, 8'h21);
        pins.set_pin(4, 1'b0);
        rd(ADDR_CTRL_FLAGS, 8'h00);
        pins.set_pin(4, 1'b1);
        rd(ADDR_VAL_LO_BASE + 8'h01, 8'h34);
        rd(ADDR_VAL_HI_BASE + 8'h01, 8'h12);
        rd(ADDR_CTRL_FLAGS, 8'h02);
        chk(16'(irq), 16'h0001);
        wr(ADDR_MODE_BASE + 8'h01, 8'h10);
        set_cnt(16'h0077);
        pins.set_pin(4, 1'b0);
        rd(ADDR_VAL_LO_BASE + 8'h01, 8'h77);
        rd(ADDR_VAL_HI_BASE + 8'h01, 8'h00);
        // Module 2 modulation: duty loads at the low byte wrap.
        wr(ADDR_VAL_HI_BASE + 8'h02, 8'h80);
        wr(ADDR_MODE_BASE + 8'h02, 8'h42);
        set_cnt(16'h00FF);
        wr(ADDR_CTRL_FLAGS, 8'h40);
        tick(1);
        settle(2);
        chk(16'({p_oe[5], p_out[5]}), 16'h0002);
        wr(ADDR_CNT_LO, 8'h90);
        settle(2);
        chk(16'({p_oe[5], p_out[5]}), 16'h0003);
        final_report();
    end
endmodule
